// ===== shared/acp_defs.svh
// Purpose: Constants for the converter output port control block
// Assumes: 200 MHz system clock
// Notes: Included by the package and the design modules
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
`define ACP_DATA_W 10
`define ACP_LSB_POS 0
`define ACP_MSB_POS 9
`define ACP_LATENCY 6
`define ACP_FIFO_DEPTH 32
`define ACP_SYNC_STAGES 3
`define ACP_MIDSCALE 10'h200
`define ACP_CODE_MAX 10'h3FF
`endif

// ===== shared/acp_pkg.sv
// Purpose: Types for the converter output port control block
// Assumes: acp_defs.svh constants
// Notes: Holds the sample word type and the operating mode type
`include "acp_defs.svh"
package acp_pkg;
  typedef logic [`ACP_DATA_W-1:0] acp_word_t;
  typedef enum logic [1:0] {ACP_RUN, ACP_STANDBY, ACP_WAKE} acp_mode_t;
endpackage

// ===== hdl/acp_fifo.sv
// Purpose: Valid/ready FIFO in the sample path
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_fifo #(
  parameter int WIDTH = `ACP_DATA_W + 1,
  parameter int DEPTH = `ACP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n) cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule // acp_fifo

// ===== hdl/acp_port_ctrl.sv
// Purpose: Digital output side of a 10-bit pipelined sampling converter
// Assumes: Raw codes arrive as offset binary; static pins are asynchronous
// Notes: Output pins are split into value and enable; pad logic forms the wire
//
// Overview of operation
// R1 - Each result is driven as a 10-bit word, bit 0 least and bit 9 most significant.
// R2 - Format select high gives two's complement, low gives straight offset binary.
// R3 - Output float high releases all data and flag pins, low drives them.
// R4 - Power-down request high puts the part in standby, low lets it convert.
// R5 - Clamp enable high closes the input clamp switch, low leaves it open.
// R6 - A new word is presented on every rising clock edge, one word per cycle; the code presents none while sink_ready is low or the FIFO is empty.
// R7 - Each word appears a fixed number of cycles after its sample was taken; the code adds a variable FIFO delay once sink_ready has been low.
// R8 - All 1024 codes of the word can be produced, none are suppressed.
// R9 - The range flag marks overflow and with the top data bit tells over from under.
// R10 - The analogue sample is captured on the falling clock edge.
// R11 - Latency is a parameter applied equally to the data word and the range flag.
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_port_ctrl
  import acp_pkg::*;
#(
  parameter int LATENCY = `ACP_LATENCY,
  parameter int FIFO_DEPTH = `ACP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core sample, valid on falling edge
  input wire logic [`ACP_DATA_W-1:0] core_code,
  input wire logic core_over,
  input wire logic core_under,
  // Static control pins
  input wire logic format_select,
  input wire logic output_float,
  input wire logic power_down_request,
  input wire logic clamp_enable,
  // Receive side back-pressure
  input wire logic sink_ready,
  // Data and flag pins
  output logic [`ACP_DATA_W-1:0] sample_word,
  output logic [`ACP_DATA_W-1:0] sample_word_oe,
  output logic range_flag,
  output logic range_flag_oe,
  output logic sample_valid,
  // Analogue controls and FIFO overrun flag
  output logic clamp_close,
  output logic standby,
  output logic fifo_overrun
);
  localparam int DW = `ACP_DATA_W;
  localparam int SS = `ACP_SYNC_STAGES;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SS-1:0] fmt_sq, flt_sq, pd_sq, clp_sq;
  logic fmt_q, flt_q, pd_q, clp_q;

  function automatic logic settle(input logic [SS-1:0] s, input logic cur);
    settle = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fmt_sq <= '0;
      flt_sq <= '1;
      pd_sq <= '0;
      clp_sq <= '0;
    end else begin
      fmt_sq <= {fmt_sq[SS-2:0], format_select};
      flt_sq <= {flt_sq[SS-2:0], output_float};
      pd_sq <= {pd_sq[SS-2:0], power_down_request};
      clp_sq <= {clp_sq[SS-2:0], clamp_enable};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fmt_q <= 1'b0;
      flt_q <= 1'b1;
      pd_q <= 1'b0;
      clp_q <= 1'b0;
    end else begin
      fmt_q <= settle(fmt_sq, fmt_q);
      flt_q <= settle(flt_sq, flt_q);
      pd_q <= settle(pd_sq, pd_q);
      clp_q <= settle(clp_sq, clp_q);
    end
  end

  // ---------------------------------------------------------------
  // Sample capture on falling edge
  // ---------------------------------------------------------------
  acp_word_t cap_q;
  logic cap_over_q;
  logic cap_under_q;

  always_ff @(negedge clk) begin
    cap_q <= core_code; // R10
    cap_over_q <= core_over; // R10
    cap_under_q <= core_under;
  end

  // ---------------------------------------------------------------
  // Standby and pipeline fill
  // ---------------------------------------------------------------
  acp_mode_t mode_q;
  logic [$clog2(LATENCY+1)-1:0] fill_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= ACP_WAKE;
    end else begin
      unique case (mode_q)
        ACP_RUN: if (pd_q) mode_q <= ACP_STANDBY; // R4
        ACP_STANDBY: if (!pd_q) mode_q <= ACP_WAKE; // R4
        ACP_WAKE: if (pd_q) mode_q <= ACP_STANDBY;
          else if (fill_q == LATENCY) mode_q <= ACP_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || mode_q != ACP_WAKE) begin
      fill_q <= '0;
    end else if (fill_q != LATENCY) begin
      fill_q <= fill_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Latency pipeline, word and flag together
  // ---------------------------------------------------------------
  logic [DW:0] pipe_q [LATENCY];
  logic [DW:0] pipe_in;

  function automatic acp_word_t fmt_word(input acp_word_t c, input logic twos);
    fmt_word = twos ? {~c[DW-1], c[DW-2:0]} : c; // R2 R8
  endfunction

  // Overflow high with MSB high means over, MSB low means under
  always_comb begin
    pipe_in = {cap_over_q | cap_under_q, cap_q}; // R9
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < LATENCY; i++) pipe_q[i] <= '0;
    end else begin
      pipe_q[0] <= pipe_in; // R6 R11
      for (int i = 1; i < LATENCY; i++) pipe_q[i] <= pipe_q[i-1]; // R7 R11
    end
  end

  // ---------------------------------------------------------------
  // Output FIFO and pins
  // ---------------------------------------------------------------
  logic f_in_ready, f_out_valid;
  logic [DW:0] f_out_data;
  logic push_ok;

  assign push_ok = mode_q == ACP_RUN;

  acp_fifo #(.WIDTH(DW + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_ok),
    .in_ready(f_in_ready),
    .in_data(pipe_q[LATENCY-1]),
    .out_valid(f_out_valid),
    .out_ready(sink_ready),
    .out_data(f_out_data)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_word <= '0;
      range_flag <= 1'b0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= f_out_valid && sink_ready; // R6
      if (f_out_valid && sink_ready) begin
        sample_word <= fmt_word(f_out_data[DW-1:0], fmt_q); // R1 R2
        range_flag <= f_out_data[DW]; // R9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_word_oe <= '0;
      range_flag_oe <= 1'b0;
    end else begin
      sample_word_oe <= {DW{~flt_q}}; // R3
      range_flag_oe <= ~flt_q; // R3
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clamp_close <= 1'b0;
      standby <= 1'b0;
      fifo_overrun <= 1'b0;
    end else begin
      clamp_close <= clp_q; // R5
      standby <= mode_q == ACP_STANDBY; // R4
      fifo_overrun <= push_ok && !f_in_ready;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence pipe_take_s;
    ##LATENCY 1'b1;
  endsequence

  latency_align_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    1'b1 |-> pipe_take_s ##0 (pipe_q[LATENCY-1] == $past(pipe_in, LATENCY)))
    else $error("pipeline latency wrong");
  float_pins_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    ##1 range_flag_oe == !$past(flt_q) && sample_word_oe[DW-1] == range_flag_oe)
    else $error("enable does not follow float");
  standby_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (mode_q == ACP_RUN && pd_q) |=> ##1 standby)
    else $error("standby not entered");
  clamp_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    ##1 clamp_close == $past(clp_q))
    else $error("clamp does not follow pin");
  twos_format_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (f_out_valid && sink_ready && fmt_q) |=> sample_word[DW-1] == !$past(f_out_data[DW-1]))
    else $error("two's complement msb wrong");
  binary_format_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (f_out_valid && sink_ready && !fmt_q) |=> sample_word == $past(f_out_data[DW-1:0]))
    else $error("binary word altered");
  flag_align_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (f_out_valid && sink_ready) |=> range_flag == $past(f_out_data[DW]))
    else $error("range flag misaligned");
  word_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (f_out_valid && sink_ready) |=> sample_valid)
    else $error("word not presented");
  code_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    $past(rst_n) |-> pipe_q[0][DW-1:0] == $past(cap_q))
    else $error("code altered in pipeline");
  share_lat_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    $past(rst_n) |-> pipe_q[0][DW] == $past(cap_over_q | cap_under_q))
    else $error("flag not in data pipeline");
endmodule // acp_port_ctrl

// ===== testbench/acp_sink_model.sv
// Purpose: Receiving logic that captures sample words
// Assumes: Pins resolved from value and enable
// Notes: Released pins show the inverse of the last value
`timescale 1ns/1ps
module acp_sink_model (
  // Clock
  input wire logic clk,
  // Pins from the block
  input wire logic [9:0] sample_word,
  input wire logic [9:0] sample_word_oe,
  input wire logic range_flag,
  input wire logic range_flag_oe,
  input wire logic format_select,
  // Bench stall control
  input wire logic accept,
  // Receive side
  output logic sink_ready,
  output logic [9:0] pin_word,
  output logic pin_flag,
  output logic over_seen,
  output logic under_seen
);
  logic [9:0] last_word_q = 10'h000;
  logic last_flag_q = 1'b0;
  assign sink_ready = accept;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pin_word[i] = sample_word_oe[i] ? sample_word[i] : ~last_word_q[i];
    end
    pin_flag = range_flag_oe ? range_flag : ~last_flag_q;
  end
  always_ff @(posedge clk) begin
    last_word_q <= pin_word;
    last_flag_q <= pin_flag;
  end
  // Flag with the top bit set in offset binary (clear in two's complement) means over, else under
  assign over_seen = pin_flag & (pin_word[9] ^ format_select);
  assign under_seen = pin_flag & ~(pin_word[9] ^ format_select);
endmodule // acp_sink_model

// ===== testbench/adc_output_port_control_tb.sv
// Purpose: Self-checking bench for the converter output port
// Assumes: Core codes count up, flags at both code ends
// Notes: Pins are decoded back to raw codes and checked in order
`timescale 1ns/1ps
module adc_output_port_control_tb;
  import acp_pkg::*;
  localparam int LAT = 4;
  logic clk = 1'b0, rst_n = 1'b0, core_over = 1'b0, core_under = 1'b0, ovr = 1'b0;
  logic format_select = 1'b0, output_float = 1'b1, power_down_request = 1'b0, clamp_enable = 1'b0;
  logic accept = 1'b0, sink_ready, range_flag, range_flag_oe, sample_valid, clamp_close, standby;
  logic fifo_overrun, pin_flag, over_seen, under_seen;
  acp_word_t core_code = '0, cnt = '0, sample_word, sample_word_oe, pin_word, prev, raw, d;
  bit seen [1024];
  bit have_prev = 0, lat_on = 1;
  int miscompares = 0, tests_run = 0, skip = 20, n;
  always #2.5 clk = ~clk;
  acp_port_ctrl #(.LATENCY(LAT), .FIFO_DEPTH(32)) u_acp_port_ctrl (.clk(clk), .rst_n(rst_n),
    .core_code(core_code), .core_over(core_over), .core_under(core_under), .format_select(format_select),
    .output_float(output_float), .power_down_request(power_down_request), .clamp_enable(clamp_enable),
    .sink_ready(sink_ready), .sample_word(sample_word), .sample_word_oe(sample_word_oe),
    .range_flag(range_flag), .range_flag_oe(range_flag_oe), .sample_valid(sample_valid),
    .clamp_close(clamp_close), .standby(standby), .fifo_overrun(fifo_overrun));
  acp_sink_model u_acp_sink_model (.clk(clk), .sample_word(sample_word), .sample_word_oe(sample_word_oe),
    .range_flag(range_flag), .range_flag_oe(range_flag_oe), .format_select(format_select),
    .accept(accept), .sink_ready(sink_ready), .pin_word(pin_word), .pin_flag(pin_flag),
    .over_seen(over_seen), .under_seen(under_seen));
  task automatic chk(input string what, input acp_word_t exp, input acp_word_t got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and core sample source
  // ----------------------------------------
  always @(negedge clk) begin
    if (fifo_overrun === 1'b1) ovr = 1'b1;
    if (skip > 0) begin
      skip--;
      have_prev = 0;
    end else if (sample_valid === 1'b1) begin
      raw = pin_word ^ (format_select ? 10'h200 : 10'h000);
      d = cnt - raw;
      if (have_prev) chk("order", prev + 10'h001, raw);
      // Capture, pipeline, one FIFO cycle and the output register
      if (lat_on) chk("latency", 10'(LAT + 3), d);
      chk("range", {8'h00, raw == 10'h3FF, raw == 10'h000}, {8'h00, over_seen, under_seen});
      seen[raw] = 1'b1;
      have_prev = 1;
      prev = raw;
    end
    core_code <= cnt;
    core_over <= (cnt == 10'h3FF);
    core_under <= (cnt == 10'h000);
    cnt = cnt + 10'h001;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hDE34EA19));
    tick(2);
    chk("oe_rst", 10'h000, sample_word_oe);
    rst_n <= 1'b1;
    accept <= 1'b1;
    tick(3);
    chk("oe_float", 10'h000, sample_word_oe);
    skip = 20;
    output_float <= 1'b0;
    tick(20);
    chk("oe_on", 10'h3FF, sample_word_oe);
    chk("flag_oe_on", 10'h001, {9'h000, range_flag_oe});
    tick(1100);
    n = 0;
    foreach (seen[i]) n += seen[i];
    chk("codes", 10'h001, {9'h000, n == 1024});
    $display("test stream done");
    skip = 20;
    format_select <= 1'b1;
    tick(200);
    chk("twos", 10'h001, {9'h000, have_prev});
    skip = 40;
    output_float <= 1'b1;
    tick(10);
    chk("oe_off", 10'h000, sample_word_oe);
    chk("flag_oe_off", 10'h000, {9'h000, range_flag_oe});
    output_float <= 1'b0;
    tick(40);
    $display("test format and float done");
    for (int k = 0; k < 4; k++) begin
      clamp_enable <= (k < 2) ? ~k[0] : 1'($urandom_range(1, 0));
      tick(6);
      chk("clamp", {9'h000, clamp_enable}, {9'h000, clamp_close});
    end
    skip = 200;
    power_down_request <= 1'b1;
    tick(60);
    chk("power_down_request_on", 10'h001, {9'h000, standby});
    chk("power_down_request_quiet", 10'h000, {9'h000, sample_valid});
    power_down_request <= 1'b0;
    tick(60);
    chk("power_down_request_off", 10'h000, {9'h000, standby});
    tick(100);
    chk("resumed", 10'h001, {9'h000, have_prev});
    $display("test clamp and standby done");
    lat_on = 0;
    repeat (300) begin
      accept <= ($urandom % 20) != 0;
      tick(1);
    end
    accept <= 1'b1;
    tick(20);
    ovr = 1'b0;
    skip = 200;
    accept <= 1'b0;
    tick(60);
    chk("overrun", 10'h001, {9'h000, ovr});
    repeat (100) begin
      accept <= 1'($urandom % 2);
      tick(1);
    end
    accept <= 1'b1;
    tick(100);
    chk("drained", 10'h001, {9'h000, have_prev});
    $display("test stall and fill done");
    end_of_test;
  end
  initial begin
    tick(6000);
    miscompares++;
    $display("[ERR] watchdog expected finish seen hang");
    end_of_test;
  end
endmodule // adc_output_port_control_tb
